// ==== verilog/system_clock_pll_config.sv ====
`timescale 1ns/1ps
// Run-mode clock control. Produces divided enables rather than gated clocks.
module system_clock_pll_config
   import clk_cfg_pkg::*;
#(
   parameter int N_PERIPH = NUM_PERIPH
)(
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic main_osc_in,
   input wire logic [DIV_W-1:0] sys_divisor_in,
   input wire logic [DIV_WIDE_W-1:0] sys_divisor_wide_in,
   input wire logic ext_cfg_select_in,
   input wire logic pll_bypass_in,
   input wire logic pll_bypass_ext_in,
   input wire logic divider_apply_in,
   input wire logic pll_power_down_in,
   input wire logic pll_power_down_ext_in,
   input wire logic [CRYSTAL_SELECT_W-1:0] crystal_select_in,
   input wire logic [OSC_W-1:0] osc_source_in,
   input wire logic [OSC_EXT_W-1:0] osc_source_ext_in,
   input wire logic cfg_write_in,
   input wire logic pll_lock_mask_in,
   input wire logic pll_lock_clear_in,
   input wire logic [N_PERIPH-1:0] periph_clk_en_in,
   output logic sys_clk_en_out,
   output logic adc_clk_en_out,
   output logic [N_PERIPH-1:0] periph_clk_en_out,
   output sys_src_t sys_src_out,
   output logic [DIV_WIDE_W-1:0] eff_divisor_out,
   output logic [OSC_EXT_W-1:0] pll_ref_sel_out,
   output logic pll_drive_out,
   output logic [TRANS_W-1:0] pll_translation_out,
   output logic pll_lock_raw_flag_out,
   output logic pll_lock_irq_out
);
   if (N_PERIPH < 1 || N_PERIPH > 32) begin : g_chk
      $error("N_PERIPH must be 1 to 32");
   end

   // Converter divisor: PLL path gives 200 MHz at the divider input.
   localparam int PLL_OUT_MHZ = PLL_VCO_MHZ / PLL_PREDIV;
   localparam int ADC_RATIO_I = PLL_OUT_MHZ / ADC_CLK_MHZ;
   localparam logic [DIV_WIDE_W-1:0] ADC_RATIO = DIV_WIDE_W'(ADC_RATIO_I);

   typedef struct packed {
      logic [2:0] osc_sync;
      logic [CRYSTAL_SELECT_W-1:0] crystal_select;
      logic pwr_dn;
      logic [RELOCK_W-1:0] relock_cnt;
      logic relocking;
      logic lock_flag;
      logic irq;
      logic [DIV_WIDE_W-1:0] div_cnt;
      logic [DIV_WIDE_W-1:0] adc_cnt;
      logic sys_en;
      logic adc_en;
      logic [N_PERIPH-1:0] periph_en;
      sys_src_t src;
      logic [DIV_WIDE_W-1:0] div_eff;
      logic [OSC_EXT_W-1:0] ref_sel;
      logic pll_drive;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic [TRANS_W-1:0] rom_data;

   pll_xlat_rom u_rom (
      .clk_sys_in(clk_sys_in),
      .nrst_in(nrst_in),
      .addr_in(s_q.crystal_select),
      .data_out(rom_data)
   );

   logic bypass_sel;
   logic pdn_sel;
   logic [DIV_WIDE_W-1:0] div_sel;
   logic [OSC_EXT_W-1:0] osc_sel;
   logic osc_rise;
   logic trigger;
   logic pll_ready;

   always_comb begin
      bypass_sel = ext_cfg_select_in ? pll_bypass_ext_in : pll_bypass_in;
      pdn_sel = ext_cfg_select_in ? pll_power_down_ext_in
                                  : pll_power_down_in;
      div_sel = ext_cfg_select_in ? sys_divisor_wide_in
                : {2'b00, sys_divisor_in};
      osc_sel = ext_cfg_select_in ? osc_source_ext_in
                : {1'b0, osc_source_in};
      osc_rise = s_q.osc_sync[1] && !s_q.osc_sync[2];
      trigger = cfg_write_in && ((crystal_select_in != s_q.crystal_select)
                || (s_q.pwr_dn && !pdn_sel));
      pll_ready = !s_q.pwr_dn && !s_q.relocking;
   end

   always_comb begin
      s_d = s_q;
      s_d.osc_sync = {s_q.osc_sync[1:0], main_osc_in};

      if (cfg_write_in) begin
         s_d.crystal_select = crystal_select_in;
         s_d.pwr_dn = pdn_sel;
         s_d.ref_sel = osc_sel;
      end

      // Relock timer advances on main oscillator edges only.
      if (trigger) begin
         s_d.relock_cnt = RELOCK_LOAD;
         s_d.relocking = 1'b1;
      end else if (s_q.relocking && osc_rise) begin
         if (s_q.relock_cnt == '0) begin
            s_d.relocking = 1'b0;
         end else begin
            s_d.relock_cnt = s_q.relock_cnt - 1'b1;
         end
      end

      if (trigger || s_d.pwr_dn) begin
         s_d.lock_flag = 1'b0;
      end else if (s_q.relocking && !s_d.relocking) begin
         s_d.lock_flag = 1'b1;
      end

      // Set wins over the software clear.
      if (s_q.relocking && !s_d.relocking && !trigger) begin
         s_d.irq = 1'b1;
      end else if (pll_lock_clear_in) begin
         s_d.irq = 1'b0;
      end

      // Source choice: PLL only once locked, otherwise the oscillator.
      if (!bypass_sel && pll_ready && !trigger) begin
         s_d.src = SRC_PLL;
      end else if (divider_apply_in || !bypass_sel) begin
         s_d.src = SRC_OSC_DIV;
      end else begin
         s_d.src = SRC_OSC_RAW;
      end
      s_d.div_eff = div_sel;

      // The PLL path carries the fixed halving of the VCO.
      if (s_d.src == SRC_OSC_RAW) begin
         s_d.sys_en = 1'b1;
         s_d.div_cnt = '0;
      end else if (s_q.div_cnt >= s_d.div_eff) begin
         s_d.sys_en = 1'b1;
         s_d.div_cnt = '0;
      end else begin
         s_d.sys_en = 1'b0;
         s_d.div_cnt = s_q.div_cnt + 1'b1;
      end

      // Converter enable drawn from system enables toward 16 MHz.
      s_d.adc_en = 1'b0;
      if (s_d.sys_en) begin
         if (s_q.adc_cnt + s_d.div_eff + 1'b1 >= ADC_RATIO) begin
            s_d.adc_en = 1'b1;
            s_d.adc_cnt = '0;
         end else begin
            s_d.adc_cnt = 6'(s_q.adc_cnt + s_d.div_eff + 1'b1);
         end
      end

      s_d.periph_en = periph_clk_en_in & {N_PERIPH{s_d.sys_en}};
      s_d.pll_drive = !s_d.pwr_dn;
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         s_q <= '0;
         s_q.crystal_select <= CRYSTAL_SELECT_RESET;
         s_q.pwr_dn <= 1'b1;
         s_q.relock_cnt <= RELOCK_LOAD;
         s_q.div_eff <= DIV_WIDE_RESET;
         s_q.src <= SRC_OSC_DIV;
      end else begin
         s_q <= s_d;
      end
   end

   logic [TRANS_W-1:0] trans_q;
   logic irq_q;
   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         trans_q <= '0;
         irq_q <= 1'b0;
      end else begin
         trans_q <= rom_data;
         irq_q <= s_q.irq && pll_lock_mask_in;
      end
   end

   assign sys_clk_en_out = s_q.sys_en;
   assign adc_clk_en_out = s_q.adc_en;
   assign periph_clk_en_out = s_q.periph_en;
   assign sys_src_out = s_q.src;
   assign eff_divisor_out = s_q.div_eff;
   assign pll_ref_sel_out = s_q.ref_sel;
   assign pll_drive_out = s_q.pll_drive;
   assign pll_translation_out = trans_q;
   assign pll_lock_raw_flag_out = s_q.lock_flag;
   assign pll_lock_irq_out = irq_q;
endmodule : system_clock_pll_config

// ==== verilog/clk_cfg_pkg.sv ====
// Operation
// - Extension-select set: extended fields replace the base fields.
// - Divide the chosen clock by base divisor plus one; reset value 0xF.
// - PLL path runs at 400 MHz and is halved before the divisor.
// - Bypass clear divides PLL output; bypass set divides the oscillator.
// - Divider-apply clear and PLL off: system clock equals the source.
// - A crystal-select change is translated into new PLL settings.
// - The PLL translation of the crystal selection is readable.
// - Extended oscillator source 0x7 selects the 32-kHz oscillator.
// - The PLL stays disabled after reset until software enables it.
// - Power-down: PLL output stopped; normal mode: PLL drives output.
// - A changed crystal value starts relock; same value does not.
// - Power-down to normal transition starts a relock period.
// - Relock timed by a down counter on the main oscillator, from 0x1200.
// - PLL is not the system clock until relock has expired.
// - Enable and select in one write: stay on oscillator until lock.
// - Raw lock flag readable; maskable lock interrupt offered.
// - Converter clock is the system clock divided down to 16 MHz.
// - Each peripheral clock is enabled or disabled individually.
package clk_cfg_pkg;
   localparam int DIV_W = 4;
   localparam int DIV_WIDE_W = DIV_W + 2;
   localparam int CRYSTAL_SELECT_W = 4;
   localparam int OSC_W = 2;
   localparam int OSC_EXT_W = 3;
   localparam int TRANS_W = 14;
   localparam int RELOCK_W = 13;
   localparam logic [DIV_W-1:0] DIV_RESET = 4'hf;
   localparam logic [DIV_WIDE_W-1:0] DIV_WIDE_RESET = 6'h0f;
   localparam logic [CRYSTAL_SELECT_W-1:0] CRYSTAL_SELECT_RESET = 4'hb;
   localparam logic [RELOCK_W-1:0] RELOCK_LOAD = 13'h1200;
   localparam logic [OSC_EXT_W-1:0] OSC_RTC_SEL = 3'h7;
   localparam int PLL_VCO_MHZ = 400;
   localparam int PLL_PREDIV = 2;
   localparam int ADC_CLK_MHZ = 16;
   localparam int NUM_PERIPH = 8;
   typedef enum logic [1:0] {
      SRC_PLL = 2'b00,
      SRC_OSC_DIV = 2'b01,
      SRC_OSC_RAW = 2'b10
   } sys_src_t;
endpackage : clk_cfg_pkg

// ==== verilog/pll_xlat_rom.sv ====
`timescale 1ns/1ps
// Crystal code to PLL setting table, read data registered.
module pll_xlat_rom
   import clk_cfg_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic [CRYSTAL_SELECT_W-1:0] addr_in,
   output logic [TRANS_W-1:0] data_out
);
   typedef struct packed {
      logic [TRANS_W-1:0] data;
   } rom_state_t;
   rom_state_t s_q;
   rom_state_t s_d;

   // Multiplier in the upper field, reference divider in the lower field.
   function automatic logic [TRANS_W-1:0] lookup(input logic [CRYSTAL_SELECT_W-1:0] a);
      logic [6:0] mul;
      logic [6:0] ref_div;
      mul = 7'(7'h32 + {3'h0, a});
      ref_div = 7'({3'h0, a} >> 1);
      return {mul, ref_div};
   endfunction : lookup

   always_comb begin
      s_d = s_q;
      s_d.data = lookup(addr_in);
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign data_out = s_q.data;
endmodule : pll_xlat_rom

// ==== dv/clk_cfg_chk.sv ====
`timescale 1ns/1ps
module clk_cfg_chk
   import clk_cfg_pkg::*;
#(
   parameter int N_PERIPH = NUM_PERIPH
)(
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic main_osc_in,
   input wire logic ext_cfg_select_in,
   input wire logic pll_bypass_in,
   input wire logic pll_bypass_ext_in,
   input wire logic pll_power_down_in,
   input wire logic pll_power_down_ext_in,
   input wire logic cfg_write_in,
   input wire logic pll_lock_mask_in,
   input wire logic [DIV_W-1:0] sys_divisor_in,
   input wire logic [DIV_WIDE_W-1:0] sys_divisor_wide_in,
   input wire logic [N_PERIPH-1:0] periph_clk_en_in,
   input wire logic sys_clk_en_out,
   input wire logic adc_clk_en_out,
   input wire logic [N_PERIPH-1:0] periph_clk_en_out,
   input wire sys_src_t sys_src_out,
   input wire logic [DIV_WIDE_W-1:0] eff_divisor_out,
   input wire logic pll_drive_out,
   input wire logic pll_lock_raw_flag_out,
   input wire logic pll_lock_irq_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   logic pdn, byp, osc_q;
   logic [13:0] edges_q;
   assign pdn = ext_cfg_select_in ? pll_power_down_ext_in : pll_power_down_in;
   assign byp = ext_cfg_select_in ? pll_bypass_ext_in : pll_bypass_in;
   // Counts oscillator edges since the PLL last left power-down.
   always_ff @(posedge clk_sys_in) begin
      osc_q <= main_osc_in;
      if (!nrst_in || $rose(pll_drive_out)) edges_q <= 14'h0;
      else if (main_osc_in && !osc_q && !edges_q[13]) edges_q <= edges_q + 14'h1;
   end
   sequence s_gap3; !sys_clk_en_out [*3] ##1 sys_clk_en_out; endsequence
   sequence s_moved;
      ##[1:4] (sys_src_out != SRC_OSC_DIV || eff_divisor_out != 6'h03);
   endsequence
   a_drive_on: assert property (cfg_write_in && !pdn |-> ##[1:2] pll_drive_out)
      else $error("pll not driving after power-up write");
   a_drive_off: assert property (cfg_write_in && pdn |-> ##[1:2] !pll_drive_out)
      else $error("pll driving after power-down write");
   a_div_select: assert property ($past(nrst_in) |-> eff_divisor_out ==
      ($past(ext_cfg_select_in) ? $past(sys_divisor_wide_in)
      : {2'b00, $past(sys_divisor_in)})) else $error("wrong divisor chosen");
   a_div_gap: assert property (sys_clk_en_out && sys_src_out == SRC_OSC_DIV
      && eff_divisor_out == 6'h03 |=> s_gap3 or s_moved)
      else $error("divide by four spacing wrong");
   a_raw_level: assert property (sys_src_out == SRC_OSC_RAW
      && $past(sys_src_out) == SRC_OSC_RAW |-> sys_clk_en_out)
      else $error("raw mode tick not level");
   a_pll_locked: assert property ($rose(sys_src_out == SRC_PLL)
      |-> $past(pll_lock_raw_flag_out)) else $error("pll used before lock");
   a_lock_switch: assert property ($rose(pll_lock_raw_flag_out) && !byp
      && pll_drive_out |=> sys_src_out == SRC_PLL) else $error("no switch");
   a_relock_min: assert property ($rose(pll_lock_raw_flag_out)
      |-> edges_q >= 14'h1200) else $error("relock too short");
   a_irq_mask: assert property (!$past(pll_lock_mask_in) |-> !pll_lock_irq_out)
      else $error("masked irq seen");
   a_irq_raise: assert property ($rose(pll_lock_raw_flag_out)
      && pll_lock_mask_in |-> ##[0:1] pll_lock_irq_out) else $error("no irq");
   a_adc_sub: assert property (adc_clk_en_out |-> sys_clk_en_out)
      else $error("converter tick without system tick");
   a_periph_gate: assert property ($past(nrst_in)
      |-> (periph_clk_en_out & ~$past(periph_clk_en_in)) == '0)
      else $error("disabled peripheral ticks");
endmodule : clk_cfg_chk
bind system_clock_pll_config clk_cfg_chk #(.N_PERIPH(N_PERIPH)) chk (.*);

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   import clk_cfg_pkg::*;
   logic clk_sys_in = 0, nrst_in = 0, main_osc_in = 0, cfg_write_in;
   logic ext_cfg_select_in, pll_bypass_in, pll_bypass_ext_in, divider_apply_in;
   logic pll_power_down_in, pll_power_down_ext_in;
   logic pll_lock_mask_in, pll_lock_clear_in;
   logic [DIV_W-1:0] sys_divisor_in, d;
   logic [DIV_WIDE_W-1:0] sys_divisor_wide_in, eff_divisor_out;
   logic [CRYSTAL_SELECT_W-1:0] crystal_select_in;
   logic [OSC_W-1:0] osc_source_in;
   logic [OSC_EXT_W-1:0] osc_source_ext_in, pll_ref_sel_out;
   logic [7:0] periph_clk_en_in, periph_clk_en_out;
   logic sys_clk_en_out, adc_clk_en_out, pll_drive_out;
   logic pll_lock_raw_flag_out, pll_lock_irq_out;
   logic [TRANS_W-1:0] pll_translation_out;
   sys_src_t sys_src_out;
   logic [39:0] q[$], e;
   logic [31:0] gap;
   int bad_count = 0, checked = 0, cyc = 0, n;
   system_clock_pll_config #(.N_PERIPH(8)) dut (.*);
   initial forever #20 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) main_osc_in <= ~main_osc_in;
   function automatic logic [31:0] obs(input logic [7:0] s);
      case (s)
         8'h0: return {26'h0, eff_divisor_out};
         8'h1: return {30'h0, sys_src_out};
         8'h2: return {31'h0, pll_drive_out};
         8'h3: return {31'h0, pll_lock_raw_flag_out};
         8'h4: return {31'h0, pll_lock_irq_out};
         8'h5: return {31'h0, sys_clk_en_out};
         8'h6: return {29'h0, pll_ref_sel_out};
         8'h7: return gap;
         8'h9: return {18'h0, pll_translation_out};
         default: return {24'h0, periph_clk_en_out};
      endcase
   endfunction : obs
   task automatic ex(input logic [7:0] s, input logic [31:0] v);
      q.push_back({s, v});
   endtask : ex
   always @(negedge clk_sys_in) begin
      while (q.size() > 0) begin
         e = q.pop_front();
         checked++;
         if (obs(e[39:32]) !== e[31:0]) begin
            bad_count++;
            $display("mismatch t=%0t got %h exp %h", $time, obs(e[39:32]), e[31:0]);
         end
      end
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         finish_test();
      end
   end
   task automatic rst();
      @(posedge clk_sys_in) nrst_in <= 1'b0;
      repeat (16) @(posedge clk_sys_in);
      ex(8'h0, 32'h0f);
      ex(8'h2, 32'h0);
      nrst_in <= 1'b1;
   endtask : rst
   // Field order: ext select, bypass, bypass ext, apply, power-down, pd ext.
   task automatic cfgw(input logic [5:0] f);
      @(posedge clk_sys_in);
      {ext_cfg_select_in, pll_bypass_in, pll_bypass_ext_in, divider_apply_in,
         pll_power_down_in, pll_power_down_ext_in} <= f;
      cfg_write_in <= 1'b1;
      @(posedge clk_sys_in);
      cfg_write_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
   endtask : cfgw
   initial begin
      {cfg_write_in, ext_cfg_select_in, pll_bypass_in, pll_bypass_ext_in,
         divider_apply_in, pll_power_down_in, pll_power_down_ext_in,
         pll_lock_mask_in, pll_lock_clear_in, sys_divisor_in,
         sys_divisor_wide_in, crystal_select_in, osc_source_in,
         osc_source_ext_in, periph_clk_en_in} = '0;
      void'($urandom(32'h783c));
      for (int i = 0; i < 2; i++) begin
         d = (i == 0) ? 4'h3 : 4'h3 + 4'($urandom_range(12));
         sys_divisor_in <= d;
         periph_clk_en_in <= 8'($urandom);
         rst();
         cfgw(6'b010111);
         ex(8'h0, {28'h0, d});
         ex(8'h1, SRC_OSC_DIV);
         @(posedge clk_sys_in iff sys_clk_en_out);
         gap = 0;
         do begin
            @(posedge clk_sys_in);
            gap++;
         end while (!sys_clk_en_out && gap < 99);
         ex(8'h7, d + 1);
         sys_divisor_wide_in <= 6'($urandom_range(63, 16));
         osc_source_ext_in <= OSC_RTC_SEL;
         cfgw(6'b111111);
         ex(8'h0, {26'h0, sys_divisor_wide_in});
         ex(8'h6, 32'h7);
         cfgw(6'b010011);
         ex(8'h1, SRC_OSC_RAW);
         ex(8'h5, 32'h1);
         ex(8'h8, {24'h0, periph_clk_en_in});
         $display("divider test %0d done", i);
      end
      // The divisor left over is 3 to 15, so the PLL path gives 12.5 to 50 MHz.
      rst();
      pll_lock_mask_in <= 1'b1;
      cfgw(6'b000101);
      ex(8'h2, 32'h1);
      ex(8'h1, SRC_OSC_DIV);
      repeat (3000) @(posedge clk_sys_in);
      crystal_select_in <= 4'h6;
      cfgw(6'b000101);
      ex(8'h3, 32'h0);
      n = 0;
      while (!pll_lock_raw_flag_out && n < 12000) begin
         @(posedge clk_sys_in);
         n++;
      end
      gap = {31'h0, n > 9000 && n < 9300};
      ex(8'h7, 32'h1);
      repeat (2) @(posedge clk_sys_in);
      ex(8'h1, SRC_PLL);
      ex(8'h4, 32'h1);
      ex(8'h9, 32'h1c03);
      cfgw(6'b000101);
      ex(8'h3, 32'h1);
      pll_lock_clear_in <= 1'b1;
      @(posedge clk_sys_in) pll_lock_clear_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      ex(8'h4, 32'h0);
      cfgw(6'b000111);
      ex(8'h2, 32'h0);
      $display("pll test done");
      finish_test();
   end
endmodule : tb_top
